// file: pkg/rtc_cal_cfg.svh
// constants for the calendar counter chain and the oscillator trim unit
// Functional notes
// - weekday steps by exactly one on each daily carry into day-of-month
// - weekday is a modulo-seven count 000 to 110, then back to 000
// - day counts 1-31 in months 1,3,5,7,8,10,12; 1-30 in 4,6,9,11
// - february counts to 29 in leap years, otherwise to 28
// - day wrapping from last day to 1 increments the month
// - month counts BCD 1 to 12; wrapping 12 to 1 increments the year
// - year counts BCD 00 to 99; every multiple of four, 00 included, is leap
// - century bit 7 of month register toggles when year wraps 99 to 00
// - all calendar fields hold and present their values in BCD
// - with power-on flag set trim reads zero; calendar unused bits read 0
// - interval select 0 applies trim at seconds 00, 20 and 40
// - interval select 1 applies trim at second 00 only
// - a correction slot coinciding with a trim write is skipped
// - sign 0 lengthens the second by (field - 1) x 2 counts
// - sign 1 shortens the second by (inverted field + 1) x 2 counts
// - a trim field of zero gives no correction whatever the sign
// - an uncorrected second is 32768 counts; sign 0 field 1 changes nothing
// - trim changes only the counts per second, never the 32.768 kHz output
// - day and weekday take the carry when the hour counter rolls over midnight
// - power-on flag clears the trim register
`ifndef RTC_CAL_CFG_SVH
`define RTC_CAL_CFG_SVH

`define RTC_ADDR_WEEKDAY 4'h3
`define RTC_ADDR_MDAY 4'h4
`define RTC_ADDR_MONTH 4'h5
`define RTC_ADDR_YEAR 4'h6
`define RTC_ADDR_TRIM 4'h7

`define RTC_MONTH_CENTURY_BIT 7
`define RTC_TRIM_INTERVAL_BIT 7
`define RTC_TRIM_SIGN_BIT 6

`define RTC_TRIM_RESET 8'h00
`define RTC_WEEKDAY_RESET 3'h0
`define RTC_MDAY_RESET 6'h01
`define RTC_MONTH_RESET 5'h01
`define RTC_YEAR_RESET 8'h00

`define RTC_WEEKDAY_LAST 3'h6
`define RTC_MONTH_LAST 5'h12
`define RTC_YEAR_LAST 8'h99
`define RTC_SEC_COUNTS 16'h8000
`define RTC_SLOT_20 7'h20
`define RTC_SLOT_40 7'h40
`define RTC_SLOT_00 7'h00

`endif

// file: pkg/rtc_cal_pkg.sv
// types and BCD helpers shared by the calendar and trim logic
package rtc_cal_pkg;
`include "rtc_cal_cfg.svh"

	typedef struct packed {
		logic [2:0] weekday;
		logic [5:0] mday;
		logic [4:0] month;
		logic century;
		logic [7:0] year;
	} calendar_s;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [3:0] addr;
		logic [7:0] wdata;
	} reg_req_s;

	typedef struct packed {
		logic interval;
		logic sign;
		logic [5:0] field;
	} trim_s;

	// BCD increment of a two-digit value
	function automatic logic [7:0] bcd_inc(input logic [7:0] v);
		if (v[3:0] == 4'h9) begin
			bcd_inc = {4'(v[7:4] + 4'h1), 4'h0};
		end else begin
			bcd_inc = {v[7:4], 4'(v[3:0] + 4'h1)};
		end
	endfunction

	// every BCD year divisible by four is leap
	function automatic logic is_leap(input logic [7:0] y);
		if (y[4]) begin
			is_leap = (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
		end else begin
			is_leap = (y[3:0] == 4'h0) || (y[3:0] == 4'h4) || (y[3:0] == 4'h8);
		end
	endfunction

	// last BCD day of a month
	function automatic logic [5:0] last_day(input logic [4:0] m, input logic [7:0] y);
		case (m)
			5'h02: last_day = is_leap(y) ? 6'h29 : 6'h28;
			5'h04, 5'h06, 5'h09, 5'h11: last_day = 6'h30;
			default: last_day = 6'h31;
		endcase
	endfunction
endpackage

// file: design/cal_step.sv
// next calendar value after one daily carry
`timescale 1ns/1ns
`default_nettype none
`include "rtc_cal_cfg.svh"
module cal_step (
	// current calendar
	input wire rtc_cal_pkg::calendar_s cur,
	// next calendar
	output rtc_cal_pkg::calendar_s nxt
);
	import rtc_cal_pkg::*;

	logic month_carry;
	logic year_carry;
	logic [7:0] mday_inc;
	logic [7:0] month_inc;

	assign mday_inc = bcd_inc({2'h0, cur.mday});
	assign month_inc = bcd_inc({3'h0, cur.month});

	always_comb begin
		nxt = cur;
		month_carry = 1'b0;
		year_carry = 1'b0;
		// weekday wraps after 110
		if (cur.weekday >= `RTC_WEEKDAY_LAST) begin
			nxt.weekday = 3'h0;
		end else begin
			nxt.weekday = 3'(cur.weekday + 3'h1);
		end
		if (cur.mday == last_day(cur.month, cur.year)) begin
			nxt.mday = 6'h01;
			month_carry = 1'b1;
		end else begin
			nxt.mday = mday_inc[5:0];
		end
		if (month_carry) begin
			if (cur.month == `RTC_MONTH_LAST) begin
				nxt.month = 5'h01;
				year_carry = 1'b1;
			end else begin
				nxt.month = month_inc[4:0];
			end
		end
		if (year_carry) begin
			if (cur.year == `RTC_YEAR_LAST) begin
				nxt.year = 8'h00;
				nxt.century = ~cur.century;
			end else begin
				nxt.year = bcd_inc(cur.year);
			end
		end
	end
endmodule // cal_step
`default_nettype wire

// file: design/trim_second_timer.sv
// one-second divider of oscillator ticks with trim correction
`timescale 1ns/1ns
`default_nettype none
`include "rtc_cal_cfg.svh"
module trim_second_timer #(
	parameter logic [15:0] SEC_COUNTS = `RTC_SEC_COUNTS
) (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	input wire logic clk_en,
	// timebase and seconds value
	input wire logic osc_tick,
	input wire logic [6:0] sec_bcd,
	// trim setting
	input wire rtc_cal_pkg::trim_s trim,
	input wire logic trim_wr,
	// second boundary
	output logic sec_tick
);
	import rtc_cal_pkg::*;

	typedef struct packed {
		logic [15:0] count;
		logic wr_seen;
		logic tick;
	} timer_s;

	timer_s s_r;
	timer_s s_nxt;
	logic slot;
	logic [15:0] target;

	always_comb begin
		s_nxt = s_r;
		s_nxt.tick = 1'b0;
		if (trim.interval) begin
			slot = (sec_bcd == `RTC_SLOT_00);
		end else begin
			slot = (sec_bcd == `RTC_SLOT_00) || (sec_bcd == `RTC_SLOT_20)
				|| (sec_bcd == `RTC_SLOT_40);
		end
		target = SEC_COUNTS;
		if (slot && !s_r.wr_seen && !trim_wr && trim.field != 6'h00) begin
			if (trim.sign) begin
				target = 16'(SEC_COUNTS - {9'h0, 6'(~trim.field) + 7'h01, 1'b0});
			end else begin
				target = 16'(SEC_COUNTS + {9'h0, 7'({1'b0, trim.field} - 7'h01), 1'b0});
			end
		end
		if (trim_wr) begin
			s_nxt.wr_seen = 1'b1;
		end
		// only the count length changes; the oscillator itself is untouched
		if (osc_tick) begin
			if (16'(s_r.count + 16'h1) >= target) begin
				s_nxt.count = 16'h0;
				s_nxt.tick = 1'b1;
				s_nxt.wr_seen = trim_wr;
			end else begin
				s_nxt.count = 16'(s_r.count + 16'h1);
			end
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			s_r <= '0;
		end else if (clk_en) begin
			s_r <= s_nxt;
		end
	end

	assign sec_tick = s_r.tick;
endmodule // trim_second_timer
`default_nettype wire

// file: design/rtc_calendar_and_trim.sv
// calendar registers, trim register and second divider of the clock
`timescale 1ns/1ns
`default_nettype none
`include "rtc_cal_cfg.svh"
module rtc_calendar_and_trim #(
	parameter logic [15:0] SEC_COUNTS = `RTC_SEC_COUNTS
) (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	input wire logic clk_en,
	// register port
	input wire rtc_cal_pkg::reg_req_s req,
	output logic [7:0] rdata,
	// timebase and time counter
	input wire logic osc_tick,
	input wire logic [6:0] sec_bcd,
	input wire logic day_carry,
	input wire logic power_on_flag,
	// outputs
	output logic sec_tick,
	output logic clk32_out
);
	import rtc_cal_pkg::*;

	typedef struct packed {
		calendar_s cal;
		trim_s trim;
		logic [7:0] rdata;
		logic clk32;
	} top_s;

	top_s s_r;
	top_s s_nxt;
	calendar_s stepped;
	logic trim_wr;
	logic tick_int;

	cal_step u_step (
		.cur(s_r.cal),
		.nxt(stepped)
	);

	trim_second_timer #(
		.SEC_COUNTS(SEC_COUNTS)
	) u_timer (
		.clk(clk),
		.reset(reset),
		.clk_en(clk_en),
		.osc_tick(osc_tick),
		.sec_bcd(sec_bcd),
		.trim(s_r.trim),
		.trim_wr(trim_wr),
		.sec_tick(tick_int)
	);

	assign trim_wr = req.wr && (req.addr == `RTC_ADDR_TRIM);

	always_comb begin
		s_nxt = s_r;
		s_nxt.clk32 = osc_tick;
		if (day_carry) begin
			s_nxt.cal = stepped;
		end
		// host writes take priority over a carry; unused bits dropped
		if (req.wr) begin
			case (req.addr)
				`RTC_ADDR_WEEKDAY: s_nxt.cal.weekday = req.wdata[2:0];
				`RTC_ADDR_MDAY: s_nxt.cal.mday = req.wdata[5:0];
				`RTC_ADDR_MONTH: begin
					s_nxt.cal.century = req.wdata[`RTC_MONTH_CENTURY_BIT];
					s_nxt.cal.month = req.wdata[4:0];
				end
				`RTC_ADDR_YEAR: s_nxt.cal.year = req.wdata;
				`RTC_ADDR_TRIM: s_nxt.trim = req.wdata;
				default: s_nxt.cal = s_nxt.cal;
			endcase
		end
		if (power_on_flag) begin
			s_nxt.trim = `RTC_TRIM_RESET;
		end
		if (req.rd) begin
			case (req.addr)
				`RTC_ADDR_WEEKDAY: s_nxt.rdata = {5'h00, s_r.cal.weekday};
				`RTC_ADDR_MDAY: s_nxt.rdata = {2'h0, s_r.cal.mday};
				`RTC_ADDR_MONTH: s_nxt.rdata = {s_r.cal.century, 2'h0, s_r.cal.month};
				`RTC_ADDR_YEAR: s_nxt.rdata = s_r.cal.year;
				`RTC_ADDR_TRIM: s_nxt.rdata = power_on_flag ? 8'h00 : s_r.trim;
				default: s_nxt.rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			s_r.cal.weekday <= `RTC_WEEKDAY_RESET;
			s_r.cal.mday <= `RTC_MDAY_RESET;
			s_r.cal.month <= `RTC_MONTH_RESET;
			s_r.cal.century <= 1'b0;
			s_r.cal.year <= `RTC_YEAR_RESET;
			s_r.trim <= `RTC_TRIM_RESET;
			s_r.rdata <= 8'h00;
			s_r.clk32 <= 1'b0;
		end else if (clk_en) begin
			s_r <= s_nxt;
		end
	end

	assign rdata = s_r.rdata;
	assign sec_tick = tick_int;
	assign clk32_out = s_r.clk32;
endmodule // rtc_calendar_and_trim
`default_nettype wire

// file: tb/rtc_cal_sva.sv
// port assertions for the calendar and trim block
`timescale 1ns/1ns
`default_nettype none
module rtc_cal_sva (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	input wire logic clk_en,
	// register port
	input wire rtc_cal_pkg::reg_req_s req,
	input wire logic [7:0] rdata,
	// timebase
	input wire logic osc_tick,
	input wire logic day_carry,
	input wire logic power_on_flag,
	// outputs
	input wire logic sec_tick,
	input wire logic clk32_out
);
	import rtc_cal_pkg::*;
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	AST_CLK32: assert property (clk_en |=> clk32_out == $past(osc_tick))
		else $error("clk32 bad");
	AST_WD_PAD: assert property (clk_en && req.rd && req.addr == 4'h3 |=> rdata[7:3] == 5'h00)
		else $error("weekday pad");
	AST_MDAY_PAD: assert property (clk_en && req.rd && req.addr == 4'h4 |=> rdata[7:6] == 2'h0)
		else $error("mday pad");
	AST_MON_PAD: assert property (clk_en && req.rd && req.addr == 4'h5 |=> rdata[6:5] == 2'h0)
		else $error("month pad");
	AST_TRIM_PON: assert property (clk_en && $past(clk_en) && power_on_flag &&
		$past(power_on_flag) && req.rd && req.addr == 4'h7 |=> rdata == 8'h00)
		else $error("trim not zero");
	AST_SEC_ONE: assert property (sec_tick && clk_en |=> !sec_tick)
		else $error("tick long");
	AST_SEC_OSC: assert property ($rose(sec_tick) |-> $past(osc_tick))
		else $error("tick no osc");
	AST_YEAR_RB: assert property (clk_en && req.wr && req.addr == 4'h6 ##1 !req.wr && !day_carry
		##1 clk_en && req.rd && !req.wr && req.addr == 4'h6 |=> rdata == $past(req.wdata, 3))
		else $error("year readback");
	cover property (clk_en && day_carry);
	cover property ($rose(sec_tick));
	cover property (power_on_flag && req.rd);
endmodule // rtc_cal_sva
bind rtc_calendar_and_trim rtc_cal_sva chk_u (.clk(clk), .reset(reset), .clk_en(clk_en),
	.req(req), .rdata(rdata), .osc_tick(osc_tick), .day_carry(day_carry),
	.power_on_flag(power_on_flag), .sec_tick(sec_tick), .clk32_out(clk32_out));
`default_nettype wire

// file: tb/host_model.sv
// host model issuing register requests
`timescale 1ns/1ns
`default_nettype none
module host_model (
	// clock
	input wire logic clk,
	// register port
	output var rtc_cal_pkg::reg_req_s req,
	input wire logic [7:0] rdata
);
	import rtc_cal_pkg::*;
	initial req = '0;
	// only existing dates, never weekday 111
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		req <= '{1'b1, 1'b0, a, d};
		@(posedge clk);
		req <= '{1'b0, 1'b0, ~a, ~d};
	endtask
	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge clk);
		req <= '{1'b0, 1'b1, a, ~req.wdata};
		@(posedge clk);
		req <= '{1'b0, 1'b0, ~a, ~req.wdata};
		#1 d = rdata;
	endtask
endmodule // host_model
`default_nettype wire

// file: tb/rtc_calendar_and_trim_bench.sv
// bench for the calendar and trim block
`timescale 1ns/1ns
`default_nettype none
module rtc_calendar_and_trim_bench;
	import rtc_cal_pkg::*;
	logic clk = 0, reset = 1, clk_en = 1, osc_tick = 0, day_carry = 0, power_on_flag = 0;
	logic [6:0] sec_bcd = 7'h10;
	logic [7:0] rdata;
	logic sec_tick, clk32_out;
	reg_req_s req;
	int n_errors = 0, checked = 0, cyc = 0, t0;
	rtc_calendar_and_trim #(.SEC_COUNTS(16'h00C8)) dut_u (.clk(clk), .reset(reset),
		.clk_en(clk_en), .req(req), .rdata(rdata), .osc_tick(osc_tick), .sec_bcd(sec_bcd),
		.day_carry(day_carry), .power_on_flag(power_on_flag), .sec_tick(sec_tick),
		.clk32_out(clk32_out));
	host_model host_u (.clk(clk), .req(req), .rdata(rdata));
	initial forever #10 clk = ~clk;
	always @(posedge clk) begin
		osc_tick <= ~osc_tick;
		cyc <= cyc + 1;
		if (cyc > 60000) begin
			n_errors++;
			final_report();
		end
	end
	task automatic final_report();
		$display("errors %0d checks %0d", n_errors, checked);
		if (n_errors == 0 && checked > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
		checked++;
		if (g !== e) begin
			n_errors++;
			$display("BAD %s exp %h got %h", s, e, g);
		end
	endtask
	task automatic rb(input logic [3:0] a, input logic [7:0] e, input string s);
		logic [7:0] v;
		host_u.rd(a, v);
		chk(s, 16'(e), 16'(v));
	endtask
	task automatic s_power_on();
		rb(4'h7, 8'h00, "trim rst");
		host_u.wr(4'h7, 8'h07);
		rb(4'h7, 8'h07, "trim");
		@(posedge clk) power_on_flag <= 1;
		host_u.wr(4'h7, 8'h55);
		rb(4'h7, 8'h00, "trim pon");
		@(posedge clk) power_on_flag <= 0;
		rb(4'h7, 8'h00, "trim after");
	endtask
	task automatic s_pads();
		host_u.wr(4'h3, 8'hF8);
		host_u.wr(4'h4, 8'hC1);
		host_u.wr(4'h5, 8'h61);
		host_u.wr(4'h9, 8'h55);
		rb(4'h3, 8'h00, "wday");
		rb(4'h4, 8'h01, "mday");
		rb(4'h5, 8'h01, "month");
		rb(4'h9, 8'h00, "unmapped");
		host_u.wr(4'h6, 8'h47);
		rb(4'h6, 8'h47, "year");
	endtask
	task automatic s_calendar();
		logic [23:0] st[6] = '{24'h280223, 24'h280224, 24'h290200, 24'h300425, 24'h300125,
			24'h311299};
		logic [23:0] ex[6] = '{24'h010323, 24'h290224, 24'h010300, 24'h010525, 24'h310125,
			24'h018100};
		for (int i = 0; i < 6; i++) begin
			host_u.wr(4'h3, 8'(i + 1));
			host_u.wr(4'h4, st[i][23:16]);
			host_u.wr(4'h5, st[i][15:8]);
			host_u.wr(4'h6, st[i][7:0]);
			@(posedge clk) day_carry <= 1;
			@(posedge clk) day_carry <= 0;
			rb(4'h3, 8'((i + 2) % 7), "wday");
			rb(4'h4, ex[i][23:16], "mday");
			rb(4'h5, ex[i][15:8], "month");
			rb(4'h6, ex[i][7:0], "year");
		end
	endtask
	task automatic s_clk32();
		logic o;
		repeat (3) begin
			@(posedge clk) o = osc_tick;
			@(negedge clk) chk("clk32", 16'(o), 16'(clk32_out));
		end
		@(posedge clk) clk_en <= 0;
		@(negedge clk) o = clk32_out;
		host_u.wr(4'h3, 8'h04);
		repeat (2) @(posedge clk);
		chk("frozen clk32", 16'(o), 16'(clk32_out));
		clk_en <= 1;
		rb(4'h3, 8'h00, "frozen wday");
	endtask
	task automatic meas(input logic [7:0] t, input logic [6:0] s, input logic [15:0] e, input bit m);
		@(posedge clk) sec_bcd <= s;
		host_u.wr(4'h7, t);
		@(posedge clk iff sec_tick === 1'b1);
		t0 = cyc;
		if (m) host_u.wr(4'h7, t);
		@(posedge clk iff sec_tick === 1'b1);
		chk("counts", e, 16'((cyc - t0) / 2));
	endtask
	task automatic s_trim();
		meas(8'h07, 7'h00, 16'h00D4, 0);
		meas(8'h07, 7'h40, 16'h00D4, 0);
		meas(8'h07, 7'h10, 16'h00C8, 0);
		meas(8'h01, 7'h00, 16'h00C8, 0);
		meas(8'hFE, 7'h00, 16'h00C4, 0);
		meas(8'hFE, 7'h20, 16'h00C8, 0);
		meas(8'h7E, 7'h20, 16'h00C4, 0);
		meas(8'h40, 7'h00, 16'h00C8, 0);
		meas(8'h07, 7'h00, 16'h00C8, 1);
	endtask
	initial begin
		repeat (5) @(posedge clk);
		reset <= 0;
		s_power_on();
		s_pads();
		s_calendar();
		s_clk32();
		s_trim();
		final_report();
	end
endmodule // rtc_calendar_and_trim_bench
`default_nettype wire
